// [src/pccu_top.sv]
// Position counters, soft limit, ring wrap and compare unit behind AHB-Lite
// Function
// - Mix two period lengths for exact average rate
// - Logical counter follows emitted drive pulses
// - Encoder counter: quadrature or up/down inputs
// - Counters are signed 32-bit two's complement
// - Host reads or writes counters anytime
// - Mode bit 14 picks limit counter
// - Plus error at >=, minus at <
// - Limit error stops drive, sets flag
// - Flag clears after reverse drive, back inside
// - Bit 13 enables, bit 15 stop type
// - Soft limit disabled after reset
// - Default maximum wraps full 32 bits
// - Programmable ring maximum wraps both ways
// - Commands 0Eh, 0Fh load ring maxima
// - Ring maxima reset to all ones
// - Four compare registers, commands 10h-13h
// - Object field selects counter, speed, timer
// - Condition field selects >=, >, =, <
// - Command 20h sets modes, 40h reads
// - Compare results readable and drive outputs
// - Compare events only on false-to-true
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
module pccu_top #(
  parameter int unsigned CLK_HZ = pccu_pkg::CLK_HZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [31:0] current_timer_value,
  output logic drive_pulse_plus,
  output logic drive_pulse_minus,
  output logic [3:0] compare_out,
  output logic [3:0] compare_event
);

  if (CLK_HZ < 2) begin : g_bad_clk
    $error("pccu_top: CLK_HZ too small");
  end

  // Ring counter step; an all-ones maximum gives plain 32-bit wrapping
  function automatic logic [31:0] ring_step(input logic [31:0] val, input logic [31:0] max,
                                            input logic up);
    if (up) begin
      ring_step = (val == max) ? 32'h0000_0000 : val + 32'h0000_0001;
    end else begin
      ring_step = (val == 32'h0000_0000) ? max : val - 32'h0000_0001;
    end
  endfunction

  function automatic logic compare(input logic [31:0] obj, input logic [31:0] ref_val,
                                   input pccu_pkg::pccu_cond_t cond);
    unique case (cond)
      pccu_pkg::PCCU_COND_GE: compare = $signed(obj) >= $signed(ref_val);
      pccu_pkg::PCCU_COND_GT: compare = $signed(obj) > $signed(ref_val);
      pccu_pkg::PCCU_COND_EQ: compare = obj == ref_val;
      pccu_pkg::PCCU_COND_LT: compare = $signed(obj) < $signed(ref_val);
    endcase
  endfunction

  typedef enum logic [1:0] {
    PCCU_IDLE,
    PCCU_RUN,
    PCCU_STOPPING
  } pccu_drive_t;

  // Bus state
  logic ph_wr_ff;
  logic ph_rd_ff;
  logic rd_wait_ff;
  logic [7:0] ph_addr_ff;
  logic [31:0] hrdata_ff;
  logic bus_take;
  logic wr_en;
  logic cmd_stb;
  logic [7:0] cmd;
  logic [31:0] wdata;
  logic [31:0] data_word;

  // Registers
  logic [15:0] mode_two_ff;
  logic [15:0] data_low_ff;
  logic [15:0] data_high_ff;
  logic [31:0] read_data_ff;
  logic [3:0] event_en_ff;
  logic [31:0] speed_ff;
  logic [31:0] logical_position_counter_ff;
  logic [31:0] encoder_position_counter_ff;
  logic [31:0] logical_ring_maximum_ff;
  logic [31:0] encoder_ring_maximum_ff;
  logic [31:0] soft_limit_plus_ff;
  logic [31:0] soft_limit_minus_ff;
  logic [31:0] compare_register_ff [4];
  logic [15:0] compare_mode_setting_ff;
  logic [3:0] compare_ff;
  logic [3:0] compare_prev_ff;

  // Drive and limit state
  pccu_drive_t drive_ff;
  logic dir_minus_ff;
  logic plus_err_ff;
  logic minus_err_ff;
  logic reverse_of_plus_ff;
  logic reverse_of_minus_ff;
  logic step;
  logic pulse_level;
  logic running;
  logic [31:0] limit_obj;
  logic plus_hit;
  logic minus_hit;
  logic limit_stop;

  // Encoder, compare inputs and read mux
  logic enc_a_ff;
  logic enc_b_ff;
  logic enc_up;
  logic enc_down;
  logic [31:0] current_speed_value;
  logic [3:0] nxt_compare;
  logic [31:0] rd_mux;

  // AHB-Lite slave: writes take no wait, reads take one wait state
  assign bus_take = hsel && hready && htrans[1];
  assign wr_en = ph_wr_ff;
  assign wdata = hwdata;
  assign data_word = {data_high_ff, data_low_ff};
  assign cmd_stb = wr_en && (ph_addr_ff == pccu_pkg::OFS_COMMAND);
  assign cmd = hwdata[7:0];
  assign hreadyout = !rd_wait_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_ff <= 1'b0;
      ph_rd_ff <= 1'b0;
      rd_wait_ff <= 1'b0;
      ph_addr_ff <= 8'h00;
    end else begin
      ph_wr_ff <= bus_take && hwrite;
      ph_rd_ff <= bus_take && !hwrite;
      rd_wait_ff <= bus_take && !hwrite;
      if (bus_take) begin
        ph_addr_ff <= {haddr[7:2], 2'b00};
      end
    end
  end

  always_comb begin
    unique case (ph_addr_ff)
      pccu_pkg::OFS_MODE_TWO: rd_mux = {16'h0000, mode_two_ff};
      pccu_pkg::OFS_DATA_LOW: rd_mux = {16'h0000, data_low_ff};
      pccu_pkg::OFS_DATA_HIGH: rd_mux = {16'h0000, data_high_ff};
      pccu_pkg::OFS_STATUS_TWO: rd_mux = {30'h000_0000, minus_err_ff, plus_err_ff};
      pccu_pkg::OFS_READ_DATA: rd_mux = read_data_ff;
      pccu_pkg::OFS_COMPARE_STATUS: rd_mux = {22'h0_0000, dir_minus_ff, running, 4'h0,
                                              compare_ff};
      pccu_pkg::OFS_EVENT_ENABLE: rd_mux = {28'h000_0000, event_en_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is sampled in the wait cycle so hrdata leaves a flip-flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (ph_rd_ff && rd_wait_ff) begin
      hrdata_ff <= rd_mux;
    end
  end

  // Plain registers written directly over the bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_two_ff <= pccu_pkg::MODE_TWO_RST;
      data_low_ff <= 16'h0000;
      data_high_ff <= 16'h0000;
      event_en_ff <= pccu_pkg::EVENT_EN_RST;
    end else if (wr_en) begin
      unique case (ph_addr_ff)
        pccu_pkg::OFS_MODE_TWO: mode_two_ff <= wdata[15:0];
        pccu_pkg::OFS_DATA_LOW: data_low_ff <= wdata[15:0];
        pccu_pkg::OFS_DATA_HIGH: data_high_ff <= wdata[15:0];
        pccu_pkg::OFS_EVENT_ENABLE: event_en_ff <= wdata[3:0];
        default: ;
      endcase
    end
  end

  // Command-loaded parameters; limits accept writes at any time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_ff <= pccu_pkg::SPEED_RST;
      logical_ring_maximum_ff <= pccu_pkg::RING_MAX_RST;
      encoder_ring_maximum_ff <= pccu_pkg::RING_MAX_RST;
      soft_limit_plus_ff <= 32'h0000_0000;
      soft_limit_minus_ff <= 32'h0000_0000;
      compare_mode_setting_ff <= 16'h0000;
    end else if (cmd_stb) begin
      unique case (cmd)
        pccu_pkg::CMD_WR_SPEED: speed_ff <= {data_high_ff, data_low_ff};
        pccu_pkg::CMD_WR_LOGICAL_MAX: logical_ring_maximum_ff <= data_word;
        pccu_pkg::CMD_WR_ENCODER_MAX: encoder_ring_maximum_ff <= data_word;
        pccu_pkg::CMD_WR_LIMIT_PLUS: soft_limit_plus_ff <= {data_high_ff, data_low_ff};
        pccu_pkg::CMD_WR_LIMIT_MINUS: soft_limit_minus_ff <= {data_high_ff, data_low_ff};
        pccu_pkg::CMD_WR_COMPARE_MODE: compare_mode_setting_ff <= data_low_ff;
        default: ;
      endcase
    end
  end

  // Compare registers: no reset value is promised, cleared for determinism
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        compare_register_ff[i] <= 32'h0000_0000;
      end
    end else if (cmd_stb && (cmd[7:2] == pccu_pkg::CMD_WR_COMPARE0[7:2])) begin
      compare_register_ff[cmd[1:0]] <= {data_high_ff, data_low_ff};
    end
  end

  // Read commands latch their answer into the read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_data_ff <= 32'h0000_0000;
    end else if (cmd_stb) begin
      if (cmd == pccu_pkg::CMD_RD_LOGICAL) begin
        read_data_ff <= logical_position_counter_ff;
      end else if (cmd == pccu_pkg::CMD_RD_ENCODER) begin
        read_data_ff <= encoder_position_counter_ff;
      end else if (cmd[7:2] == pccu_pkg::CMD_RD_COMPARE0[7:2]) begin
        read_data_ff <= compare_register_ff[cmd[1:0]];
      end else if (cmd == pccu_pkg::CMD_RD_COMPARE_MODE) begin
        read_data_ff <= {16'h0000, compare_mode_setting_ff};
      end
    end
  end

  // Soft limit against the selected counter
  assign limit_obj = mode_two_ff[pccu_pkg::M2_LIMIT_OBJ] ? encoder_position_counter_ff
                                                         : logical_position_counter_ff;
  assign plus_hit = $signed(limit_obj) >= $signed(soft_limit_plus_ff);
  assign minus_hit = $signed(limit_obj) < $signed(soft_limit_minus_ff);
  assign limit_stop = running && ((plus_err_ff && !dir_minus_ff) ||
                                  (minus_err_ff && dir_minus_ff));

  // A flag is sticky: setting wins over the reverse-drive clear in the same cycle; clearing bit 13 clears both flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      plus_err_ff <= 1'b0;
      minus_err_ff <= 1'b0;
    end else if (!mode_two_ff[pccu_pkg::M2_LIMIT_EN]) begin
      plus_err_ff <= 1'b0;
      minus_err_ff <= 1'b0;
    end else begin
      if (plus_hit) begin
        plus_err_ff <= 1'b1;
      end else if (reverse_of_plus_ff) begin
        plus_err_ff <= 1'b0;
      end
      if (minus_hit) begin
        minus_err_ff <= 1'b1;
      end else if (reverse_of_minus_ff) begin
        minus_err_ff <= 1'b0;
      end
    end
  end

  // Remembers that an opposite-direction drive was commanded after the error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reverse_of_plus_ff <= 1'b0;
      reverse_of_minus_ff <= 1'b0;
    end else begin
      if (!plus_err_ff) begin
        reverse_of_plus_ff <= 1'b0;
      end else if (cmd_stb && cmd == pccu_pkg::CMD_DRIVE_MINUS) begin
        reverse_of_plus_ff <= 1'b1;
      end
      if (!minus_err_ff) begin
        reverse_of_minus_ff <= 1'b0;
      end else if (cmd_stb && cmd == pccu_pkg::CMD_DRIVE_PLUS) begin
        reverse_of_minus_ff <= 1'b1;
      end
    end
  end

  // Drive control; decelerating stop finishes the pulse in flight because
  // no acceleration profile is modelled here
  assign running = drive_ff != PCCU_IDLE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_ff <= PCCU_IDLE;
      dir_minus_ff <= 1'b0;
    end else begin
      unique case (drive_ff)
        PCCU_IDLE: begin
          if (cmd_stb && cmd[7:1] == pccu_pkg::CMD_DRIVE_PLUS[7:1]) begin
            drive_ff <= PCCU_RUN;
            dir_minus_ff <= cmd[0];
          end
        end
        PCCU_RUN: begin
          if ((cmd_stb && cmd == pccu_pkg::CMD_STOP_INSTANT) ||
              (limit_stop && mode_two_ff[pccu_pkg::M2_STOP_INSTANT])) begin
            drive_ff <= PCCU_IDLE;
          end else if ((cmd_stb && cmd == pccu_pkg::CMD_STOP_DECEL) || limit_stop) begin
            drive_ff <= PCCU_STOPPING;
          end
        end
        PCCU_STOPPING: begin
          if (step || (cmd_stb && cmd == pccu_pkg::CMD_STOP_INSTANT)) begin
            drive_ff <= PCCU_IDLE;
          end
        end
      endcase
    end
  end

  pccu_pulse_gen #(
    .CLK_HZ(CLK_HZ)
  ) u_pulse_gen (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(running),
    .speed(speed_ff),
    .step(step),
    .pulse_out(pulse_level)
  );

  // Pins are registered so the direction split adds no glitch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_pulse_plus <= 1'b0;
      drive_pulse_minus <= 1'b0;
    end else begin
      drive_pulse_plus <= pulse_level && !dir_minus_ff;
      drive_pulse_minus <= pulse_level && dir_minus_ff;
    end
  end

  // Host write wins over a count in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      logical_position_counter_ff <= 32'h0000_0000;
    end else if (cmd_stb && cmd == pccu_pkg::CMD_WR_LOGICAL) begin
      logical_position_counter_ff <= {data_high_ff, data_low_ff};
    end else if (step) begin
      logical_position_counter_ff <= ring_step(logical_position_counter_ff,
                                               logical_ring_maximum_ff, !dir_minus_ff);
    end
  end

  // Encoder decode: inputs are synchronous, previous levels kept for edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enc_a_ff <= 1'b0;
      enc_b_ff <= 1'b0;
    end else begin
      enc_a_ff <= enc_a;
      enc_b_ff <= enc_b;
    end
  end

  always_comb begin
    if (mode_two_ff[pccu_pkg::M2_ENC_UPDOWN]) begin
      enc_up = enc_a && !enc_a_ff && !(enc_b && !enc_b_ff);
      enc_down = enc_b && !enc_b_ff && !(enc_a && !enc_a_ff);
    end else begin
      // One count per quadrature edge; a double change is dropped as invalid
      enc_up = ((enc_a ^ enc_a_ff) && (enc_a != enc_b)) ||
               ((enc_b ^ enc_b_ff) && (enc_a == enc_b));
      enc_down = ((enc_a ^ enc_a_ff) && (enc_a == enc_b)) ||
                 ((enc_b ^ enc_b_ff) && (enc_a != enc_b));
      if ((enc_a ^ enc_a_ff) && (enc_b ^ enc_b_ff)) begin
        enc_up = 1'b0;
        enc_down = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      encoder_position_counter_ff <= 32'h0000_0000;
    end else if (cmd_stb && cmd == pccu_pkg::CMD_WR_ENCODER) begin
      encoder_position_counter_ff <= {data_high_ff, data_low_ff};
    end else if (enc_up || enc_down) begin
      encoder_position_counter_ff <= ring_step(encoder_position_counter_ff,
                                               encoder_ring_maximum_ff, enc_up);
    end
  end

  // Compare against live objects
  assign current_speed_value = running ? speed_ff : 32'h0000_0000;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      logic [31:0] obj;
      obj = logical_position_counter_ff;
      unique case (pccu_pkg::pccu_obj_t'(compare_mode_setting_ff[4*i +: 2]))
        pccu_pkg::PCCU_OBJ_LOGICAL: obj = logical_position_counter_ff;
        pccu_pkg::PCCU_OBJ_ENCODER: obj = encoder_position_counter_ff;
        pccu_pkg::PCCU_OBJ_SPEED: obj = current_speed_value;
        pccu_pkg::PCCU_OBJ_TIMER: obj = current_timer_value;
      endcase
      nxt_compare[i] = compare(obj, compare_register_ff[i],
                               pccu_pkg::pccu_cond_t'(compare_mode_setting_ff[4*i+2 +: 2]));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_ff <= 4'h0;
      compare_prev_ff <= 4'h0;
    end else begin
      compare_ff <= nxt_compare;
      compare_prev_ff <= compare_ff;
    end
  end

  // Edge detection ensures an already-true result raises no event when enabled
  assign compare_out = compare_ff;
  assign compare_event = compare_ff & ~compare_prev_ff & event_en_ff;

endmodule

// [shared/pccu_pkg.sv]
// Shared constants and types of the position counter and compare unit
package pccu_pkg;

  // System clock rate
  localparam int unsigned CLK_HZ = 25_000_000;

  // AHB-Lite byte offsets of the software-visible registers
  localparam logic [7:0] OFS_COMMAND = 8'h00;
  localparam logic [7:0] OFS_MODE_TWO = 8'h04;
  localparam logic [7:0] OFS_DATA_LOW = 8'h08;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h0C;
  localparam logic [7:0] OFS_STATUS_TWO = 8'h10;
  localparam logic [7:0] OFS_READ_DATA = 8'h14;
  localparam logic [7:0] OFS_COMPARE_STATUS = 8'h18;
  localparam logic [7:0] OFS_EVENT_ENABLE = 8'h1C;

  // Command codes written to the command register
  localparam logic [7:0] CMD_WR_SPEED = 8'h05;
  localparam logic [7:0] CMD_WR_LOGICAL = 8'h09;
  localparam logic [7:0] CMD_WR_ENCODER = 8'h0A;
  localparam logic [7:0] CMD_WR_LIMIT_PLUS = 8'h0B;
  localparam logic [7:0] CMD_WR_LIMIT_MINUS = 8'h0C;
  localparam logic [7:0] CMD_WR_LOGICAL_MAX = 8'h0E;
  localparam logic [7:0] CMD_WR_ENCODER_MAX = 8'h0F;
  localparam logic [7:0] CMD_WR_COMPARE0 = 8'h10;
  localparam logic [7:0] CMD_WR_COMPARE_MODE = 8'h20;
  localparam logic [7:0] CMD_RD_LOGICAL = 8'h30;
  localparam logic [7:0] CMD_RD_ENCODER = 8'h31;
  localparam logic [7:0] CMD_RD_COMPARE0 = 8'h34;
  localparam logic [7:0] CMD_RD_COMPARE_MODE = 8'h40;
  localparam logic [7:0] CMD_DRIVE_PLUS = 8'h60;
  localparam logic [7:0] CMD_DRIVE_MINUS = 8'h61;
  localparam logic [7:0] CMD_STOP_DECEL = 8'h66;
  localparam logic [7:0] CMD_STOP_INSTANT = 8'h67;

  // Bit positions in mode_register_two
  localparam int M2_ENC_UPDOWN = 0;
  localparam int M2_LIMIT_EN = 13;
  localparam int M2_LIMIT_OBJ = 14;
  localparam int M2_STOP_INSTANT = 15;

  // Bit positions in status_register_two and the compare status word
  localparam int ST2_PLUS_ERR = 0;
  localparam int ST2_MINUS_ERR = 1;
  localparam int CS_RUNNING = 8;
  localparam int CS_DIR_MINUS = 9;

  // Values after reset
  localparam logic [15:0] MODE_TWO_RST = 16'h0000;
  localparam logic [31:0] RING_MAX_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] SPEED_RST = 32'h0000_0000;
  localparam logic [3:0] EVENT_EN_RST = 4'h0;

  typedef enum logic [1:0] {
    PCCU_OBJ_LOGICAL,
    PCCU_OBJ_ENCODER,
    PCCU_OBJ_SPEED,
    PCCU_OBJ_TIMER
  } pccu_obj_t;

  typedef enum logic [1:0] {
    PCCU_COND_GE,
    PCCU_COND_GT,
    PCCU_COND_EQ,
    PCCU_COND_LT
  } pccu_cond_t;

endpackage

// [src/pccu_pulse_gen.sv]
// Drive pulse generator with fractional period accumulation
module pccu_pulse_gen #(
  parameter int unsigned CLK_HZ = pccu_pkg::CLK_HZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [31:0] speed,
  output logic step,
  output logic pulse_out
);

  if (CLK_HZ < 2 || CLK_HZ > 32'h7FFF_FFFF) begin : g_bad_clk
    $error("pccu_pulse_gen: CLK_HZ out of range");
  end

  localparam logic [31:0] HZ = 32'(CLK_HZ);
  localparam logic [31:0] HALF = 32'(CLK_HZ / 2);

  logic [31:0] acc_ff;
  logic [31:0] spd;
  logic [31:0] sum;
  logic [31:0] nxt_acc;
  logic wrap;

  // The accumulator overflows on average at the requested rate, capped at half the clock, so the period
  // alternates between the two neighbouring whole counts of clocks.
  always_comb begin
    spd = (speed > HALF) ? HALF : speed;
    sum = acc_ff + spd;
    wrap = run && (sum >= HZ);
    nxt_acc = wrap ? (sum - HZ) : (run ? sum : 32'h0000_0000);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_ff <= 32'h0000_0000;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // Pin is low for the first half of each period and high for the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step <= 1'b0;
      pulse_out <= 1'b0;
    end else begin
      step <= wrap;
      pulse_out <= run && (nxt_acc >= HALF);
    end
  end

endmodule

// [dv/pccu_checker.sv]
// Concurrent checks on the bus handshake, drive pins and compare events
module pccu_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic drive_pulse_plus,
  input wire logic drive_pulse_minus,
  input wire logic [3:0] compare_out,
  input wire logic [3:0] compare_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic take = hsel && hready && htrans[1];
  property p_read_wait;
    take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
  property p_wait_one;
    !hreadyout |=> hreadyout;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait too long");
  property p_write_nowait;
    take && hwrite |=> hreadyout;
  endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
  property p_hrdata_hold;
    take && hwrite |=> $stable(hrdata);
  endproperty
  a_hrdata_hold: assert property (p_hrdata_hold) else $error("hrdata moved");
  property p_hresp;
    hresp == 1'b0;
  endproperty
  a_hresp: assert property (p_hresp) else $error("hresp not okay");
  property p_one_dir;
    !(drive_pulse_plus && drive_pulse_minus);
  endproperty
  a_one_dir: assert property (p_one_dir) else $error("both pins high");
  property p_evt_rise;
    (compare_event & ~(compare_out & ~$past(compare_out))) == 4'h0;
  endproperty
  a_evt_rise: assert property (p_evt_rise) else $error("event not on rise");
  property p_evt_out;
    (compare_event & $past(compare_event)) == 4'h0;
  endproperty
  a_evt_out: assert property (p_evt_out) else $error("event held too long");
endmodule

// [dv/pccu_enc_model.sv]
// Encoder model: quadrature pairs or separate up and down pulses
module pccu_enc_model (
  input wire logic hclk,
  output logic enc_a,
  output logic enc_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph = 2'h0;
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
  end
  // Quadrature levels and separate pulses hold three cycles, the low gap before a separate pulse two, so no edge is too short to count
  task automatic move(input int n, input bit up, input bit sep);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      if (sep) begin
        {enc_a, enc_b} <= 2'h0;
        repeat (2) @(posedge hclk);
        {enc_a, enc_b} <= up ? 2'h2 : 2'h1;
      end else begin
        ph = up ? ph + 2'h1 : ph - 2'h1;
        {enc_a, enc_b} <= {ph[1] ^ ph[0], ph[1]};
      end
      repeat (2) @(posedge hclk);
    end
  endtask
endmodule

// [dv/tb_top.sv]
// Testbench: bus tasks, reference arithmetic and directed scenarios
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pp = 1'b0, pm = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, tmr = 32'h0000_0000, hrdata;
  logic hreadyout, hresp, enc_a, enc_b, dpp, dpm;
  logic [3:0] cmp_o, cmp_e;
  int miscompares = 0, n_tests = 0, nf = 0;
  always #20 hclk = ~hclk;
  pccu_top i_pccu_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .enc_a, .enc_b,
    .current_timer_value(tmr), .drive_pulse_plus(dpp), .drive_pulse_minus(dpm),
    .compare_out(cmp_o), .compare_event(cmp_e));
  pccu_enc_model i_pccu_enc_model (.hclk, .enc_a, .enc_b);
  // The counter steps on the same clock edge as the pin falls, so falling edges are counted
  always @(posedge hclk) begin
    pp <= dpp;
    pm <= dpm;
    if ((pp && !dpp) || (pm && !dpm)) nf <= nf + 1;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(a, 1'b0, 32'h0000_0000, d);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [31:0] d);
    wr(pccu_pkg::OFS_DATA_LOW, {16'h0000, d[15:0]});
    wr(pccu_pkg::OFS_DATA_HIGH, {16'h0000, d[31:16]});
    wr(pccu_pkg::OFS_COMMAND, {24'h00_0000, c});
  endtask
  task automatic rcmd(input logic [7:0] c, output logic [31:0] d);
    cmd(c, 32'h0000_0000);
    rd(pccu_pkg::OFS_READ_DATA, d);
  endtask
  function automatic longint ring(longint v, longint m);
    return ((v % m) + m) % m;
  endfunction
  function automatic bit cmpf(int o, int r, int c);
    case (c)
      0: return o >= r;
      1: return o > r;
      2: return o == r;
      default: return o < r;
    endcase
  endfunction
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge hclk);
    miscompares++;
    print_verdict;
  end
  initial begin
    logic [31:0] v, md, r[4];
    longint m, s;
    int ov[4], d, nb, n0;
    bit [3:0] e;
    void'($urandom(73));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(pccu_pkg::OFS_MODE_TWO, v);
    chk("mode_two", v, {16'h0000, pccu_pkg::MODE_TWO_RST});
    rd(8'h3C, v);
    chk("unmapped", v, 32'h0000_0000);
    $display("Test reset done");
    cmd(pccu_pkg::CMD_WR_SPEED, 32'h002D_C6C0);
    for (int i = 0; i < 4; i++) begin
      m = (i < 2) ? 64'h1_0000_0000 : 10;
      s = (i == 0) ? 64'hFFFF_FFF0 : (i == 1) ? 10 : $urandom % 10;
      d = (i % 2 == 0) ? 1 : -1;
      if (i > 0) cmd(pccu_pkg::CMD_WR_LOGICAL_MAX, 32'(m - 1));
      cmd(pccu_pkg::CMD_WR_LOGICAL, 32'(s));
      nb = nf;
      cmd(d > 0 ? pccu_pkg::CMD_DRIVE_PLUS : pccu_pkg::CMD_DRIVE_MINUS, 32'h0000_0000);
      repeat (100) @(posedge hclk);
      n0 = nf;
      repeat (2500) @(posedge hclk);
      chk("rate", 32'(nf - n0 >= 299 && nf - n0 <= 301), 32'h0000_0001);
      cmd(pccu_pkg::CMD_STOP_DECEL, 32'h0000_0000);
      repeat (40) @(posedge hclk);
      rcmd(pccu_pkg::CMD_RD_LOGICAL, v);
      chk("logical", v, 32'(ring(s + d * (nf - nb), m)));
    end
    $display("Test ring done");
    cmd(pccu_pkg::CMD_WR_ENCODER_MAX, 32'h0000_0009);
    cmd(pccu_pkg::CMD_WR_ENCODER, 32'h0000_0008);
    i_pccu_enc_model.move(3, 1'b1, 1'b0);
    rcmd(pccu_pkg::CMD_RD_ENCODER, v);
    chk("enc_quad", v, 32'h0000_0001);
    wr(pccu_pkg::OFS_MODE_TWO, 32'h0000_0001);
    i_pccu_enc_model.move(2, 1'b0, 1'b1);
    rcmd(pccu_pkg::CMD_RD_ENCODER, v);
    chk("enc_updown", v, 32'h0000_0009);
    $display("Test encoder done");
    cmd(pccu_pkg::CMD_WR_LOGICAL_MAX, 32'hFFFF_FFFF);
    cmd(pccu_pkg::CMD_WR_LOGICAL, 32'h0000_0000);
    cmd(pccu_pkg::CMD_WR_LIMIT_PLUS, 32'h0000_0005);
    cmd(pccu_pkg::CMD_WR_LIMIT_MINUS, 32'hFFFF_FC18);
    wr(pccu_pkg::OFS_MODE_TWO, 32'h0000_A000);
    nb = nf;
    cmd(pccu_pkg::CMD_DRIVE_PLUS, 32'h0000_0000);
    repeat (200) @(posedge hclk);
    rd(pccu_pkg::OFS_STATUS_TWO, v);
    chk("plus_err", 32'(v[1:0]), 32'h0000_0001);
    rd(pccu_pkg::OFS_COMPARE_STATUS, v);
    chk("running", 32'(v[pccu_pkg::CS_RUNNING]), 32'h0000_0000);
    rcmd(pccu_pkg::CMD_RD_LOGICAL, v);
    chk("stop_pos", v, 32'(nf - nb));
    chk("at_limit", 32'($signed(v) == 5), 32'h0000_0001);
    cmd(pccu_pkg::CMD_DRIVE_MINUS, 32'h0000_0000);
    repeat (60) @(posedge hclk);
    cmd(pccu_pkg::CMD_STOP_INSTANT, 32'h0000_0000);
    repeat (40) @(posedge hclk);
    rd(pccu_pkg::OFS_STATUS_TWO, v);
    chk("err_clear", 32'(v[1:0]), 32'h0000_0000);
    wr(pccu_pkg::OFS_MODE_TWO, 32'h0000_6000);
    rd(pccu_pkg::OFS_STATUS_TWO, v);
    chk("enc_limit", 32'(v[1:0]), 32'h0000_0001);
    wr(pccu_pkg::OFS_MODE_TWO, 32'h0000_0000);
    $display("Test limit done");
    wr(pccu_pkg::OFS_EVENT_ENABLE, 32'h0000_000F);
    for (int k = 0; k < 4; k++) begin
      ov = '{$urandom % 64, 9, 0, $urandom % 1000};
      tmr <= 32'(ov[3]);
      md = 32'h0000_0000;
      for (int n = 0; n < 4; n++) begin
        r[n] = 32'(ov[n] + int'($urandom % 3) - 1);
        md[4 * n +: 4] = {2'(n + k), 2'(n)};
        e[n] = cmpf(ov[n], r[n], (n + k) % 4);
        cmd(8'(pccu_pkg::CMD_WR_COMPARE0 + n), r[n]);
      end
      cmd(pccu_pkg::CMD_WR_COMPARE_MODE, md);
      cmd(pccu_pkg::CMD_WR_LOGICAL, 32'(ov[0]));
      repeat (3) @(posedge hclk);
      rd(pccu_pkg::OFS_COMPARE_STATUS, v);
      chk("compare", 32'(v[3:0]), 32'(e));
      chk("cmp_out", 32'(cmp_o), 32'(e));
      rcmd(pccu_pkg::CMD_RD_COMPARE_MODE, v);
      chk("cmp_mode", v, md);
      for (int n = 0; n < 4; n++) begin
        rcmd(8'(pccu_pkg::CMD_RD_COMPARE0 + n), v);
        chk("cmp_reg", v, r[n]);
      end
    end
    $display("Test compare done");
    print_verdict;
  end
endmodule
bind pccu_top pccu_checker i_pccu_checker (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .drive_pulse_plus, .drive_pulse_minus,
  .compare_out, .compare_event);
